// ==== mitc_pkg.sv ====
// Constants and types for the instruction timing core.
// Assumes nothing beyond a SystemVerilog compiler.
package mitc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [7:0] BYTE_MAX = 8'h00FF;

  // ****************************************************************
  // Instruction encoding: op[15:12], bit index [10:8], operand [7:0].
  // ****************************************************************
  localparam int unsigned OP_HI = 15;
  localparam int unsigned OP_LO = 12;
  localparam int unsigned DST_BIT = 11;
  localparam int unsigned BIT_HI = 10;
  localparam int unsigned BIT_LO = 8;
  localparam logic [7:0] PC_LOW_ADDR = 8'h0002;
  localparam logic [7:0] TBL_HI_RESET = 8'h0000;
  localparam logic [11:0] PC_RESET = 12'h0000;
  localparam logic [7:0] ACC_RESET = 8'h0000;
  localparam logic [1:0] SECTOR0 = 2'h0;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_INVERT, OP_INCDEC,
    OP_ROT, OP_BITSET, OP_MOVE, OP_SKIP, OP_JUMP, OP_CALL, OP_RETURN, OP_MISC
  } mitc_op_type;

  typedef enum {
    ST_RUN, ST_EXTRA, ST_HALT
  } mitc_state_type;

endpackage

// ==== mitc_core.sv ====
// Instruction sequencer and datapath of an 8-bit accumulator core.
// Assumes program and data memory answer combinationally within a cycle.
`timescale 1ns/1ps
`default_nettype none

module mitc_core #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [15:0] PM_DATA,
  input wire logic [7:0] DM_RDATA,
  input wire logic WAKE,
  output logic [11:0] PM_ADDR,
  output logic [9:0] DM_ADDR,
  output logic [7:0] DM_WDATA,
  output logic DM_WE,
  output logic [7:0] ACC,
  output logic CARRY,
  output logic ZERO,
  output logic IRQ_EN,
  output logic SLEEP,
  output logic INSTR_DONE
);

  // ****************************************************************
  // Instruction fields
  // Encoding inside each group: OP_ADD/OP_SUB [11]=dst mem [10]=carry,
  // OP_INCDEC [10]=decrement, OP_ROT [10]=left [9]=through carry,
  // OP_BITSET [11]=set, OP_MOVE [10]=acc to mem [9]=immediate,
  // OP_SKIP [10]=not-zero [9]=bit test, OP_RETURN [10]=interrupt return,
  // A skip bit test shares [10:9] with its bit index, so it reaches
  // bits 2, 3, 6 and 7 only.
  // OP_MISC [10]=halt else table read (address {tbl_hi, acc}).
  // ****************************************************************
  logic [1:0] phase_q;
  mitc_pkg::mitc_state_type state_q;
  logic [11:0] pc_q;
  logic [15:0] ir_q;
  logic [7:0] acc_q;
  logic carry_q;
  logic zero_q;
  logic irq_en_q;
  logic [7:0] tbl_hi_q;
  logic [11:0] stack_q [STACK_DEPTH];
  localparam int SP_W = $clog2(STACK_DEPTH);
  logic [SP_W-1:0] sp_q;
  logic sleep_q;
  logic skip_q;
  logic done_q;
  logic we_q;
  logic [7:0] wd_q;

  wire logic [15:0] ins = (state_q == mitc_pkg::ST_RUN) ? PM_DATA : ir_q;
  wire mitc_pkg::mitc_op_type op =
    mitc_pkg::mitc_op_type'(ins[mitc_pkg::OP_HI:mitc_pkg::OP_LO]);
  wire logic [7:0] opd = ins[7:0];
  wire logic [2:0] bidx = ins[mitc_pkg::BIT_HI:mitc_pkg::BIT_LO];
  wire logic to_mem = ins[mitc_pkg::DST_BIT];
  wire logic at_end = (phase_q == mitc_pkg::PHASE_LAST);

  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h0000);
  endfunction

  // ****************************************************************
  // Arithmetic and logic; add, subtract, and, or and xor work against the accumulator
  // ****************************************************************
  logic [8:0] sum;
  logic [7:0] res;
  logic res_c;
  logic res_z_upd;
  logic c_upd;
  logic writes_acc;
  logic writes_mem;
  logic take_skip;
  always_comb begin
    sum = 9'h0000;
    res = acc_q;
    res_c = carry_q;
    res_z_upd = 1'b0;
    c_upd = 1'b0;
    writes_acc = 1'b0;
    writes_mem = 1'b0;
    take_skip = 1'b0;
    case (op)
      mitc_pkg::OP_ADD: begin
        sum = {1'b0, acc_q} + {1'b0, DM_RDATA} + {8'h0000, ins[10] & carry_q};
        res = sum[7:0];
        res_c = (sum > {1'b0, mitc_pkg::BYTE_MAX});
        c_upd = 1'b1;
        res_z_upd = 1'b1;
        writes_acc = !to_mem;
        writes_mem = to_mem;
      end
      mitc_pkg::OP_SUB: begin
        sum = {1'b0, acc_q} - {1'b0, DM_RDATA} - {8'h0000, ins[10] & ~carry_q};
        res = sum[7:0];
        res_c = ~sum[8]; // carry clear means borrow.
        c_upd = 1'b1;
        res_z_upd = 1'b1;
        writes_acc = !to_mem;
        writes_mem = to_mem;
      end
      mitc_pkg::OP_AND, mitc_pkg::OP_OR, mitc_pkg::OP_XOR,
      mitc_pkg::OP_INVERT: begin
        case (op)
          mitc_pkg::OP_AND: res = acc_q & DM_RDATA;
          mitc_pkg::OP_OR: res = acc_q | DM_RDATA;
          mitc_pkg::OP_XOR: res = acc_q ^ DM_RDATA;
          default: res = ~DM_RDATA;
        endcase
        res_z_upd = 1'b1;
        writes_acc = !to_mem;
        writes_mem = to_mem;
      end
      mitc_pkg::OP_INCDEC: begin
        res = ins[10] ? DM_RDATA - 8'h0001 : DM_RDATA + 8'h0001;
        res_z_upd = 1'b1;
        writes_acc = !to_mem;
        writes_mem = to_mem;
      end
      mitc_pkg::OP_ROT: begin
        if (ins[10]) begin
          res = {DM_RDATA[6:0], ins[9] ? carry_q : DM_RDATA[7]};
          res_c = DM_RDATA[7];
        end else begin
          res = {ins[9] ? carry_q : DM_RDATA[0], DM_RDATA[7:1]};
          res_c = DM_RDATA[0];
        end
        c_upd = ins[9];
        writes_acc = !to_mem;
        writes_mem = to_mem;
      end
      mitc_pkg::OP_BITSET: begin
        res = DM_RDATA;
        res[bidx] = ins[mitc_pkg::DST_BIT];
        writes_mem = 1'b1;
      end
      mitc_pkg::OP_MOVE: begin
        res = ins[10] ? acc_q : (ins[9] ? opd : DM_RDATA);
        writes_acc = !ins[10];
        writes_mem = ins[10];
      end
      mitc_pkg::OP_SKIP: begin
        take_skip = ins[9] ? (DM_RDATA[bidx] == ins[10])
                           : (is_zero(DM_RDATA) != ins[10]);
      end
      default: begin
        res = acc_q;
      end
    endcase
  end

  // Program counter low written: any memory write aimed at its address.
  wire logic pc_low_write = writes_mem && (opd == mitc_pkg::PC_LOW_ADDR);
  wire logic two_cycle =
    (op == mitc_pkg::OP_JUMP) || (op == mitc_pkg::OP_CALL) ||
    (op == mitc_pkg::OP_RETURN) || (op == mitc_pkg::OP_MISC && !ins[10]) ||
    pc_low_write || take_skip;
  wire logic [11:0] pc_inc = pc_q + 12'h0001;

  // ****************************************************************
  // Phase counter: four system clocks per instruction cycle
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RESET_N || state_q == mitc_pkg::ST_HALT) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_q <= mitc_pkg::ST_RUN;
      ir_q <= 16'h0000;
      skip_q <= 1'b0;
      done_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        mitc_pkg::ST_RUN: begin
          if (at_end) begin
            ir_q <= PM_DATA;
            if (skip_q) begin
              skip_q <= 1'b0;
              done_q <= 1'b1;
            end else if (op == mitc_pkg::OP_MISC && ins[10]) begin
              state_q <= mitc_pkg::ST_HALT;
              sleep_q <= 1'b1;
              done_q <= 1'b1;
            end else if (take_skip) begin
              skip_q <= 1'b1;
            end else if (two_cycle) begin
              state_q <= mitc_pkg::ST_EXTRA;
            end else begin
              done_q <= 1'b1;
            end
          end
        end
        mitc_pkg::ST_EXTRA: begin
          if (at_end) begin
            state_q <= mitc_pkg::ST_RUN;
            done_q <= 1'b1;
          end
        end
        mitc_pkg::ST_HALT: begin
          if (WAKE) begin
            state_q <= mitc_pkg::ST_RUN;
            sleep_q <= 1'b0;
          end
        end
        default: begin
          state_q <= mitc_pkg::ST_RUN;
        end
      endcase
    end
  end

  // A taken skip spends its extra cycle fetching and discarding the
  // next word, so the skipped instruction is never executed.
  wire logic exec = (state_q == mitc_pkg::ST_RUN) && at_end && !skip_q;

  // ****************************************************************
  // Program counter and return stack
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pc_q <= mitc_pkg::PC_RESET;
      sp_q <= '0;
    end else if (exec) begin
      case (op)
        mitc_pkg::OP_JUMP: pc_q <= ins[11:0]; // no save.
        mitc_pkg::OP_CALL: begin
          stack_q[sp_q] <= pc_inc;
          sp_q <= sp_q + SP_W'(1);
          pc_q <= ins[11:0];
        end
        mitc_pkg::OP_RETURN: begin
          pc_q <= stack_q[sp_q - SP_W'(1)];
          sp_q <= sp_q - SP_W'(1);
        end
        default: begin
          if (pc_low_write) begin
            pc_q <= {pc_q[11:8], res};
          end else begin
            // Halt steps on too, so that a wake resumes after it.
            pc_q <= pc_inc;
          end
        end
      endcase
    end else if (state_q == mitc_pkg::ST_RUN && at_end) begin
      pc_q <= pc_inc;
    end
  end

  // ****************************************************************
  // Accumulator, flags, interrupt enable and table high byte
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      acc_q <= mitc_pkg::ACC_RESET;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      irq_en_q <= 1'b0;
      tbl_hi_q <= mitc_pkg::TBL_HI_RESET;
    end else if (exec) begin
      if (writes_acc) acc_q <= res;
      if (c_upd) carry_q <= res_c;
      if (res_z_upd) zero_q <= is_zero(res);
      if (op == mitc_pkg::OP_RETURN && ins[10]) irq_en_q <= 1'b1;
      if (op == mitc_pkg::OP_MOVE && ins[10] && ins[9]) tbl_hi_q <= acc_q;
    end else if (state_q == mitc_pkg::ST_EXTRA && at_end &&
                 ir_q[mitc_pkg::OP_HI:mitc_pkg::OP_LO] == 4'hF) begin
      acc_q <= PM_DATA[7:0];
    end
  end

  // ****************************************************************
  // Memory ports and outputs
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      we_q <= 1'b0;
      wd_q <= 8'h0000;
    end else begin
      we_q <= exec && writes_mem;
      wd_q <= res;
    end
  end

  wire logic tbl_fetch = (state_q == mitc_pkg::ST_EXTRA) &&
    (ir_q[mitc_pkg::OP_HI:mitc_pkg::OP_LO] == 4'hF);
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PM_ADDR <= mitc_pkg::PC_RESET;
      DM_ADDR <= 10'h0000;
    end else begin
      PM_ADDR <= tbl_fetch ? {tbl_hi_q[3:0], acc_q} : pc_q;
      DM_ADDR <= {mitc_pkg::SECTOR0, opd};
    end
  end

  assign DM_WE = we_q;
  assign DM_WDATA = wd_q;
  assign ACC = acc_q;
  assign CARRY = carry_q;
  assign ZERO = zero_q;
  assign IRQ_EN = irq_en_q;
  assign SLEEP = sleep_q;
  assign INSTR_DONE = done_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_phase_wrap;
    @(posedge CLK) disable iff (!RESET_N)
    (phase_q == 2'h3 && state_q != mitc_pkg::ST_HALT) |=> phase_q == 2'h0;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase wrap");

  property p_extra_len;
    @(posedge CLK) disable iff (!RESET_N)
    $rose(state_q == mitc_pkg::ST_EXTRA) |-> ##3 at_end;
  endproperty
  a_extra_len: assert property (p_extra_len) else $error("extra len");

  property p_irq_return;
    @(posedge CLK) disable iff (!RESET_N)
    (exec && op == mitc_pkg::OP_RETURN && ins[10]) |=> IRQ_EN;
  endproperty
  a_irq_return: assert property (p_irq_return) else $error("irq enable");

  property p_sub_return;
    @(posedge CLK) disable iff (!RESET_N)
    (exec && op == mitc_pkg::OP_RETURN && !ins[10]) |=> $stable(IRQ_EN);
  endproperty
  a_sub_return: assert property (p_sub_return) else $error("irq kept");

  property p_zero_logic;
    @(posedge CLK) disable iff (!RESET_N)
    (exec && op == mitc_pkg::OP_AND) |=> ZERO == is_zero($past(res));
  endproperty
  a_zero_logic: assert property (p_zero_logic) else $error("zero");

  property p_sector;
    @(posedge CLK) disable iff (!RESET_N) DM_ADDR[9:8] == 2'h0;
  endproperty
  a_sector: assert property (p_sector) else $error("sector");

  property p_halt;
    @(posedge CLK) disable iff (!RESET_N)
    (exec && op == mitc_pkg::OP_MISC && ins[10]) |=> SLEEP;
  endproperty
  a_halt: assert property (p_halt) else $error("halt");

  property p_call;
    @(posedge CLK) disable iff (!RESET_N)
    (exec && op == mitc_pkg::OP_CALL) |=> stack_q[$past(sp_q)] == $past(pc_inc);
  endproperty
  a_call: assert property (p_call) else $error("call save");

  property p_one_cycle;
    @(posedge CLK) disable iff (!RESET_N)
    (exec && !two_cycle && op != mitc_pkg::OP_MISC) |=> INSTR_DONE;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("one cycle");

  c_call: cover property (@(posedge CLK) exec && op == mitc_pkg::OP_CALL);
  c_skip: cover property (@(posedge CLK) exec && take_skip);
  c_pc_low: cover property (@(posedge CLK) exec && pc_low_write);

endmodule

`default_nettype wire

// ==== mitc_mem.sv ====
// Behavioural program and data memory that face the instruction core.
// Assumes the core drives registered addresses and a one-cycle write pulse.
`timescale 1ns/1ps
`default_nettype none

module mitc_mem (
  input wire logic clk,
  input wire logic [11:0] pm_addr,
  input wire logic [9:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we,
  output logic [15:0] pm_data,
  output logic [7:0] dm_rdata
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  // Plain always is used so that the bench may preload both arrays.
  logic [15:0] pm [0:4095];
  logic [7:0] dm [0:1023];

  // Code and table words share one array, as a table read expects.
  assign pm_data = pm[pm_addr];
  assign dm_rdata = dm[dm_addr];

  always @(posedge clk) begin
    if (dm_we) begin
      dm[dm_addr] <= dm_wdata;
    end
  end
endmodule

`default_nettype wire

// ==== mitc_core_bench.sv ====
// Self-checking bench for the instruction timing core.
// Assumes the memory model answers combinationally on the core's addresses.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(nm, exp, got) begin check_count++; \
  if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module mitc_core_bench;
  logic clk, reset_n, wake, dm_we, carry, zero, irq_en, sleep, done;
  logic [15:0] pm_data;
  logic [7:0] dm_rdata, dm_wdata, acc;
  logic [11:0] pm_addr, watch;
  logic [9:0] dm_addr;
  logic saw;
  int error_cnt, check_count, cyc;

  mitc_core i_mitc_core (.CLK(clk), .RESET_N(reset_n), .PM_DATA(pm_data),
    .DM_RDATA(dm_rdata), .WAKE(wake), .PM_ADDR(pm_addr), .DM_ADDR(dm_addr),
    .DM_WDATA(dm_wdata), .DM_WE(dm_we), .ACC(acc), .CARRY(carry),
    .ZERO(zero), .IRQ_EN(irq_en), .SLEEP(sleep), .INSTR_DONE(done));

  mitc_mem i_mitc_mem (.clk(clk), .pm_addr(pm_addr), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .pm_data(pm_data),
    .dm_rdata(dm_rdata));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] w(logic [3:0] op, logic dst, logic [7:0] a);
    return {op, dst, 3'h0, a};
  endfunction

  task automatic put_pm(input int a, input logic [15:0] d);
    i_mitc_mem.pm[a] = d;
  endtask

  task automatic put_dm(input int a, input logic [7:0] d);
    i_mitc_mem.dm[a] = d;
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Clears both memories, then resets the core for three clocks.
  task automatic start();
    for (int i = 0; i < 4096; i++) put_pm(i, 16'h0000);
    for (int i = 0; i < 1024; i++) put_dm(i, 8'h00);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    `CHECK("acc_rst", 8'h00, acc)
    `CHECK("done_rst", 1'b0, done)
    reset_n = 1'b1;
  endtask

  // Waits for the next retired instruction; a gap of 0 skips the count.
  task automatic step(input int gap);
    int n;
    n = 0;
    saw = 1'b0;
    do begin
      @(negedge clk);
      n++;
      if (pm_addr === watch) saw = 1'b1;
    end while (done !== 1'b1 && n < 40);
    if (gap > 0) `CHECK("gap", gap, n)
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_arith();
    start();
    put_dm(8'h10, 8'hF0);
    put_dm(8'h11, 8'h20);
    put_pm(1, w(mitc_pkg::OP_ADD, 1'b0, 8'h10));
    put_pm(2, w(mitc_pkg::OP_ADD, 1'b0, 8'h11));
    put_pm(3, w(mitc_pkg::OP_SUB, 1'b0, 8'h11));
    put_pm(4, w(mitc_pkg::OP_SUB, 1'b0, 8'h11));
    step(4);
    step(4);
    `CHECK("acc", 8'hF0, acc)
    step(4);
    `CHECK("carry", 1'b1, carry)
    `CHECK("acc", 8'h10, acc)
    step(4);
    `CHECK("borrow", 1'b0, carry)
    step(4);
    `CHECK("acc", 8'hD0, acc)
    `CHECK("noborrow", 1'b1, carry)
  endtask

  task automatic t_logic();
    start();
    put_dm(8'h20, 8'h0F);
    put_dm(8'h21, 8'hF0);
    put_dm(8'h22, 8'hFF);
    put_pm(1, w(mitc_pkg::OP_ADD, 1'b0, 8'h20));
    put_pm(2, w(mitc_pkg::OP_AND, 1'b0, 8'h21));
    put_pm(3, w(mitc_pkg::OP_OR, 1'b0, 8'h22));
    put_pm(4, w(mitc_pkg::OP_XOR, 1'b0, 8'h22));
    put_pm(5, w(mitc_pkg::OP_ADD, 1'b0, 8'h20));
    put_pm(6, w(mitc_pkg::OP_INVERT, 1'b0, 8'h22));
    repeat (3) step(4);
    `CHECK("and_z", 1'b1, zero)
    step(4);
    `CHECK("or_z", 1'b0, zero)
    step(4);
    `CHECK("xor_z", 1'b1, zero)
    repeat (2) step(4);
    `CHECK("inv_acc", 8'h00, acc)
    `CHECK("inv_z", 1'b1, zero)
  endtask

  task automatic t_mem();
    start();
    put_dm(8'h30, 8'h05);
    put_pm(1, w(mitc_pkg::OP_ADD, 1'b0, 8'h30));
    put_pm(2, w(mitc_pkg::OP_ADD, 1'b1, 8'h30));
    repeat (3) step(4);
    `CHECK("we", 1'b1, dm_we)
    `CHECK("waddr", 10'h030, dm_addr)
    `CHECK("wdata", 8'h0A, dm_wdata)
    `CHECK("acc", 8'h05, acc)
    step(4);
    `CHECK("mem", 8'h0A, i_mitc_mem.dm[8'h30])
  endtask

  // The target does not depend on whether the low byte reads 2 or 3.
  task automatic t_pc_low();
    start();
    put_dm(8'h02, 8'h02);
    put_dm(8'h40, 8'h23);
    put_dm(8'h41, 8'h33);
    put_dm(8'h42, 8'hFF);
    put_pm(1, w(mitc_pkg::OP_ADD, 1'b0, 8'h40));
    put_pm(2, w(mitc_pkg::OP_OR, 1'b1, mitc_pkg::PC_LOW_ADDR));
    put_pm(3, w(mitc_pkg::OP_ADD, 1'b0, 8'h42));
    put_pm(8'h23, w(mitc_pkg::OP_ADD, 1'b0, 8'h41));
    repeat (2) step(4);
    step(8);
    step(4);
    `CHECK("acc", 8'h56, acc)
  endtask

  task automatic t_branch();
    start();
    put_dm(8'h50, 8'h01);
    put_dm(8'h51, 8'h80);
    put_pm(0, {4'hC, 12'h010});
    put_pm(1, w(mitc_pkg::OP_ADD, 1'b0, 8'h51));
    put_pm(8'h10, {4'hD, 12'h020});
    put_pm(8'h11, w(mitc_pkg::OP_ADD, 1'b0, 8'h50));
    put_pm(8'h20, w(mitc_pkg::OP_ADD, 1'b0, 8'h50));
    put_pm(8'h21, {4'hE, 12'h000});
    step(8);
    step(8);
    step(4);
    `CHECK("acc_sub", 8'h01, acc)
    step(8);
    step(4);
    `CHECK("acc_back", 8'h02, acc)
    `CHECK("irq_en", 1'b0, irq_en)
  endtask

  task automatic t_table();
    start();
    put_dm(8'h60, 8'h05);
    put_pm(1, w(mitc_pkg::OP_ADD, 1'b0, 8'h60));
    put_pm(2, 16'hF000);
    put_pm(5, 16'h00AA);
    watch = 12'h005;
    repeat (2) step(4);
    step(8);
    `CHECK("tbl_addr", 1'b1, saw)
    `CHECK("tbl_acc", 8'hAA, acc)
    watch = 12'hFFF;
  endtask

  // Rotate, decrement, bit set, both skip outcomes and an interrupt return.
  task automatic t_misc();
    start();
    put_dm(8'h80, 8'h81);
    put_pm(1, 16'h8680);
    put_pm(2, 16'h7481);
    put_pm(3, 16'h9B81);
    put_pm(4, 16'hB081);
    put_pm(5, 16'hB481);
    put_pm(6, w(mitc_pkg::OP_ADD, 1'b0, 8'h80));
    put_pm(7, w(mitc_pkg::OP_ADD, 1'b0, 8'h81));
    put_pm(8, 16'hD090);
    put_pm(8'h90, 16'hE400);
    repeat (2) step(4);
    `CHECK("rot_acc", 8'h02, acc)
    `CHECK("rot_c", 1'b1, carry)
    step(4);
    `CHECK("dec_acc", 8'hFF, acc)
    repeat (2) step(4);
    `CHECK("bit_set", 8'h08, i_mitc_mem.dm[8'h81])
    step(8);
    step(4);
    `CHECK("skip_acc", 8'h07, acc)
    step(8);
    step(8);
    `CHECK("irq_back", 1'b1, irq_en)
  endtask

  task automatic t_halt();
    int n;
    start();
    n = 0;
    put_dm(8'h70, 8'h07);
    put_pm(0, 16'hF400);
    put_pm(1, w(mitc_pkg::OP_ADD, 1'b0, 8'h70));
    repeat (12) @(negedge clk);
    `CHECK("sleep", 1'b1, sleep)
    repeat (20) begin
      @(negedge clk);
      if (done === 1'b1) n++;
    end
    `CHECK("halt_done", 0, n)
    wake = 1'b1;
    step(0);
    wake = 1'b0;
    `CHECK("acc", 8'h07, acc)
    `CHECK("awake", 1'b0, sleep)
  endtask

  // ****************************************************************
  // Clock, timeout and sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Each scenario needs well under a hundred clocks.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    reset_n = 1'b0;
    wake = 1'b0;
    watch = 12'hFFF;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    t_arith();
    t_logic();
    t_mem();
    t_pc_low();
    t_branch();
    t_table();
    t_misc();
    t_halt();
    wrap_up();
  end
endmodule

`default_nettype wire
